// ---- hdl/flag_ops_pkg.sv ----
// Purpose: Shared constants and types for the status-flag bit operation unit.
// Assumes: Eight-bit status flags and eight-bit working registers.
// Notes: Flag indices follow the usual status layout, carry in bit 0.
package flag_ops_pkg;

  // ==========================================================================
  // Flag positions
  localparam logic [2:0] FLAG_CARRY = 3'h0;
  localparam logic [2:0] FLAG_ZERO = 3'h1;
  localparam logic [2:0] FLAG_NEGATIVE = 3'h2;
  localparam logic [2:0] FLAG_OVERFLOW = 3'h3;
  localparam logic [2:0] FLAG_SIGN = 3'h4;
  localparam logic [2:0] FLAG_HALF = 3'h5;
  localparam logic [2:0] FLAG_TRANSFER = 3'h6;
  localparam logic [2:0] FLAG_INTERRUPT = 3'h7;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Operation codes
  typedef enum logic [4:0] {
    op_nop,
    op_sleep,
    flag_set_by_index,
    flag_clear_by_index,
    register_bit_to_transfer_flag,
    transfer_flag_to_register_bit,
    carry_set_op,
    carry_clear_op,
    negative_set_op,
    negative_clear_op,
    zero_set_op,
    zero_clear_op,
    interrupt_enable_op,
    interrupt_disable_op,
    sign_test_set_op,
    sign_test_clear_op,
    overflow_set_op,
    overflow_clear_op,
    transfer_flag_clear_op,
    half_carry_set_op,
    half_carry_clear_op
  } flag_op_t;

  typedef struct packed {
    logic valid;
    flag_op_t op;
    logic [2:0] index;
    logic [7:0] reg_value;
  } flag_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } reg_write_t;

endpackage : flag_ops_pkg

// ---- hdl/status_flag_bit_instructions.sv ----
// Purpose: One-cycle execution of single-bit status flag operations.
// Assumes: Commands come from logic on clk; reg_value holds the named register.
// Notes: Result register writes and status flags are registered.
`timescale 1ns/100ps
module status_flag_bit_instructions (
  input wire logic clk,
  input wire logic rst_n,
  input wire flag_ops_pkg::flag_cmd_t cmd,
  output logic [7:0] status_flags,
  output flag_ops_pkg::reg_write_t reg_write,
  output logic sleep_request
);

  // ==========================================================================
  // State
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  flag_ops_pkg::reg_write_t wr_r;
  flag_ops_pkg::reg_write_t wr_nxt;
  logic sleep_r;
  logic sleep_nxt;

  // Status flag layout, lowest bit first, follows the package positions:
  // carry, zero, negative, overflow, sign test, half carry, transfer, interrupt.
  // Only this unit writes the flags, so no set and clear race has to be settled.
  // The register file lives outside; a write hands back the whole new byte, so
  // the outside logic needs no read-modify-write of its own.

  // True when a valid command of the given operation is presented this cycle.
  function automatic logic op_is(input flag_ops_pkg::flag_cmd_t c,
                                 input flag_ops_pkg::flag_op_t o);
    return c.valid && (c.op == o);
  endfunction : op_is

  // Returns flags with one bit forced, so no operation touches more than one flag.
  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] i,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[i] = b;
    return r;
  endfunction : put_bit

  // ==========================================================================
  // Next-state logic
  // Every operation finishes at the edge that takes it, so the flags need no
  // busy state and a command may follow on every cycle.
  always_comb begin
    flags_nxt = flags_r;
    if (cmd.valid) begin
      unique case (cmd.op)
        flag_ops_pkg::op_nop: begin
          flags_nxt = flags_r;
        end
        flag_ops_pkg::op_sleep: begin
          // Entering sleep leaves the flags alone; the pulse is made below.
          flags_nxt = flags_r;
        end
        // The indexed forms reach every flag, the transfer flag included.
        // An index is taken as given, since all eight codes name a flag.
        flag_ops_pkg::flag_set_by_index: begin
          flags_nxt = put_bit(flags_r, cmd.index, 1'b1);
        end
        flag_ops_pkg::flag_clear_by_index: begin
          flags_nxt = put_bit(flags_r, cmd.index, 1'b0);
        end
        // The bit is read from the register byte presented with the command,
        // which the outside logic must supply in the same cycle.
        flag_ops_pkg::register_bit_to_transfer_flag: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_TRANSFER,
                              cmd.reg_value[cmd.index]);
        end
        flag_ops_pkg::transfer_flag_to_register_bit: begin
          // The write itself is built in the register write group below.
          flags_nxt = flags_r;
        end
        // Carry forms are the indexed forms at the carry position.
        flag_ops_pkg::carry_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_CARRY, 1'b1);
        end
        flag_ops_pkg::carry_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_CARRY, 1'b0);
        end
        // Negative and zero forms each touch their own flag only.
        flag_ops_pkg::negative_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_NEGATIVE, 1'b1);
        end
        flag_ops_pkg::negative_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_NEGATIVE, 1'b0);
        end
        flag_ops_pkg::zero_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_ZERO, 1'b1);
        end
        flag_ops_pkg::zero_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_ZERO, 1'b0);
        end
        // Interrupt forms are the indexed forms at the interrupt position.
        // Any delay before a new enable takes effect belongs to the core.
        flag_ops_pkg::interrupt_enable_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_INTERRUPT, 1'b1);
        end
        flag_ops_pkg::interrupt_disable_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_INTERRUPT, 1'b0);
        end
        // Sign test and overflow forms are forced directly, not recomputed.
        flag_ops_pkg::sign_test_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_SIGN, 1'b1);
        end
        flag_ops_pkg::sign_test_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_SIGN, 1'b0);
        end
        flag_ops_pkg::overflow_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_OVERFLOW, 1'b1);
        end
        flag_ops_pkg::overflow_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_OVERFLOW, 1'b0);
        end
        // Clearing the transfer flag leaves the other seven bits as they are.
        flag_ops_pkg::transfer_flag_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_TRANSFER, 1'b0);
        end
        // Half carry forms touch only the half carry flag.
        flag_ops_pkg::half_carry_set_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_HALF, 1'b1);
        end
        flag_ops_pkg::half_carry_clear_op: begin
          flags_nxt = put_bit(flags_r, flag_ops_pkg::FLAG_HALF, 1'b0);
        end
        default: begin
          // Unused opcode values behave as a no-op rather than corrupt flags.
          flags_nxt = flags_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // Status flag registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= flag_ops_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================================
  // Register write group
  // The write uses the transfer flag as it stood after the previous edge, so a
  // flag change just before is seen here without any forwarding path.
  always_comb begin
    wr_nxt = '0;
    if (op_is(cmd, flag_ops_pkg::transfer_flag_to_register_bit)) begin
      wr_nxt.valid = 1'b1;
      wr_nxt.value = put_bit(cmd.reg_value, cmd.index,
                             flags_r[flag_ops_pkg::FLAG_TRANSFER]);
    end
  end

  // Valid and value fall back to zero after one cycle; the outside logic must
  // take the byte in the cycle in which it stands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  // ==========================================================================
  // Sleep request group
  // A one-cycle pulse only; holding the core asleep is the sleep controller's job.
  always_comb begin
    sleep_nxt = 1'b0;
    if (op_is(cmd, flag_ops_pkg::op_sleep)) begin
      sleep_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // All outputs come straight from flip-flops, so no command path reaches a pin.
  assign status_flags = flags_r;
  assign reg_write = wr_r;
  assign sleep_request = sleep_r;

endmodule : status_flag_bit_instructions

// ---- testbench/flag_ops_properties.sv ----
// Purpose: Port checks for the status flag operation unit.
// Assumes: One command per cycle; idle cycles carry no check.
// Notes: Earlier flags and command are kept locally to judge each result.
`timescale 1ns/100ps
module flag_ops_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire flag_ops_pkg::flag_cmd_t cmd,
  input wire logic [7:0] status_flags,
  input wire flag_ops_pkg::reg_write_t reg_write,
  input wire logic sleep_request
);
  // ==========================================================================
  // Properties
  flag_ops_pkg::flag_cmd_t c_r;
  logic [7:0] pf_r;
  logic [7:0] ins;
  always_ff @(posedge clk) begin
    c_r <= cmd;
    pf_r <= status_flags;
  end
  always_comb begin
    ins = c_r.reg_value;
    ins[c_r.index] = pf_r[6];
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_fix(o1, o0, m);
    cmd.valid && (cmd.op == o1 || cmd.op == o0) |=>
      status_flags == ((pf_r & ~m) | ((c_r.op == o1) ? m : 8'h00));
  endproperty
  a_transfer_copy: assert property (
    cmd.valid && cmd.op == flag_ops_pkg::register_bit_to_transfer_flag |=>
    status_flags == {pf_r[7], c_r.reg_value[c_r.index], pf_r[5:0]}) else $error("copy bad");
  a_transfer_write: assert property (
    cmd.valid && cmd.op == flag_ops_pkg::transfer_flag_to_register_bit |=>
    reg_write.valid && reg_write.value == ins && status_flags == pf_r) else $error("write bad");
  a_half_carry_ops: assert property (p_fix(flag_ops_pkg::half_carry_set_op,
    flag_ops_pkg::half_carry_clear_op, 8'h20)) else $error("half carry bad");
  a_overflow_ops: assert property (p_fix(flag_ops_pkg::overflow_set_op,
    flag_ops_pkg::overflow_clear_op, 8'h08)) else $error("overflow bad");
  a_sign_test_ops: assert property (p_fix(flag_ops_pkg::sign_test_set_op,
    flag_ops_pkg::sign_test_clear_op, 8'h10)) else $error("sign bad");
  a_negative_ops: assert property (p_fix(flag_ops_pkg::negative_set_op,
    flag_ops_pkg::negative_clear_op, 8'h04)) else $error("negative bad");
  a_quiet_ops: assert property (
    cmd.valid && cmd.op inside {flag_ops_pkg::op_nop, flag_ops_pkg::op_sleep} |=>
    status_flags == pf_r && sleep_request == (c_r.op == flag_ops_pkg::op_sleep))
    else $error("quiet bad");
  a_zero_ops: assert property (p_fix(flag_ops_pkg::zero_set_op,
    flag_ops_pkg::zero_clear_op, 8'h02)) else $error("zero bad");
  a_carry_ops: assert property (p_fix(flag_ops_pkg::carry_set_op,
    flag_ops_pkg::carry_clear_op, 8'h01)) else $error("carry bad");
  a_interrupt_ops: assert property (p_fix(flag_ops_pkg::interrupt_enable_op,
    flag_ops_pkg::interrupt_disable_op, 8'h80)) else $error("interrupt bad");
  a_index_ops: assert property (
    cmd.valid && cmd.op inside {flag_ops_pkg::flag_set_by_index, flag_ops_pkg::flag_clear_by_index}
    |=> status_flags == ((c_r.op == flag_ops_pkg::flag_set_by_index) ?
    (pf_r | (8'h01 << c_r.index)) : (pf_r & ~(8'h01 << c_r.index)))) else $error("index bad");
  c_sleep: cover property (sleep_request);
  c_write: cover property (reg_write.valid);
  c_flag_t: cover property (status_flags[6] ##1 !status_flags[6]);
endmodule : flag_ops_checker
bind status_flag_bit_instructions flag_ops_checker flag_ops_checker_inst (.clk(clk),
  .rst_n(rst_n), .cmd(cmd), .status_flags(status_flags), .reg_write(reg_write),
  .sleep_request(sleep_request));

// ---- testbench/status_flag_bit_instructions_tb_top.sv ----
// Purpose: Directed bench for the status flag operation unit.
// Assumes: Results show just after the edge that takes a command.
// Notes: Expected flags are built bit by bit from the flag positions.
`timescale 1ns/100ps
module status_flag_bit_instructions_tb_top;
  // ==========================================================================
  // Stimulus and checks
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  flag_ops_pkg::flag_cmd_t cmd = '0;
  logic [7:0] status_flags;
  flag_ops_pkg::reg_write_t reg_write;
  logic sleep_request;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] exp;
  always #5 clk = ~clk;
  status_flag_bit_instructions status_flag_bit_instructions_inst (.clk(clk), .rst_n(rst_n),
    .cmd(cmd), .status_flags(status_flags), .reg_write(reg_write),
    .sleep_request(sleep_request));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic go(input flag_ops_pkg::flag_op_t o, input logic [2:0] i, input logic [7:0] v);
    @(posedge clk);
    cmd <= '{1'b1, o, i, v};
  endtask : go
  // Valid drops on the taking edge, so each call is exactly one command.
  task automatic run(input flag_ops_pkg::flag_op_t o, input logic [2:0] i, input logic [7:0] v);
    go(o, i, v);
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask : run
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic t_index;
    exp = 8'h00;
    for (int k = 0; k < 8; k++) begin
      run(flag_ops_pkg::flag_set_by_index, 3'(k), 8'h00);
      exp[k] = 1'b1;
      chk("index set", status_flags, exp);
    end
    run(flag_ops_pkg::flag_clear_by_index, 3'h7, 8'h00);
    chk("index clear", status_flags, 8'h7f);
    $display("index test done");
  endtask : t_index
  task automatic t_named;
    flag_ops_pkg::flag_op_t cl[8] = '{flag_ops_pkg::carry_clear_op, flag_ops_pkg::zero_clear_op,
      flag_ops_pkg::negative_clear_op, flag_ops_pkg::overflow_clear_op,
      flag_ops_pkg::sign_test_clear_op, flag_ops_pkg::half_carry_clear_op,
      flag_ops_pkg::transfer_flag_clear_op, flag_ops_pkg::interrupt_disable_op};
    flag_ops_pkg::flag_op_t st[8] = '{flag_ops_pkg::carry_set_op, flag_ops_pkg::zero_set_op,
      flag_ops_pkg::negative_set_op, flag_ops_pkg::overflow_set_op,
      flag_ops_pkg::sign_test_set_op, flag_ops_pkg::half_carry_set_op,
      flag_ops_pkg::flag_set_by_index, flag_ops_pkg::interrupt_enable_op};
    exp = 8'h7f;
    for (int k = 0; k < 8; k++) begin
      run(cl[k], 3'h0, 8'h00);
      exp[k] = 1'b0;
      chk("named clear", status_flags, exp);
    end
    for (int k = 0; k < 8; k++) begin
      run(st[k], 3'(k), 8'h00);
      exp[k] = 1'b1;
      chk("named set", status_flags, exp);
    end
    $display("named test done");
  endtask : t_named
  task automatic t_transfer;
    go(flag_ops_pkg::register_bit_to_transfer_flag, 3'h3, 8'hf7);
    run(flag_ops_pkg::transfer_flag_to_register_bit, 3'h0, 8'hff);
    chk("write valid", {7'h00, reg_write.valid}, 8'h01);
    chk("write value", reg_write.value, 8'hfe);
    chk("copy flags", status_flags, 8'hbf);
    run(flag_ops_pkg::register_bit_to_transfer_flag, 3'h3, 8'h08);
    chk("write pulse", {7'h00, reg_write.valid}, 8'h00);
    chk("copy one", status_flags, 8'hff);
    $display("transfer test done");
  endtask : t_transfer
  task automatic t_sleep;
    run(flag_ops_pkg::op_sleep, 3'h0, 8'h00);
    chk("sleep pulse", {7'h00, sleep_request}, 8'h01);
    chk("sleep flags", status_flags, 8'hff);
    run(flag_ops_pkg::op_nop, 3'h0, 8'h00);
    chk("nop pulse", {7'h00, sleep_request}, 8'h00);
    chk("nop flags", status_flags, 8'hff);
    $display("sleep test done");
  endtask : t_sleep
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset flags", status_flags, flag_ops_pkg::FLAGS_RESET);
    t_index;
    t_named;
    t_transfer;
    t_sleep;
    test_done;
  end
endmodule : status_flag_bit_instructions_tb_top
